/* phsr_consts.svh */
// Purpose: constants for the protection and hypervisor system-register block
// Assumes: 64-bit system-register data, 25 MHz core clock
// Notes: encodings, field positions, masks and alignment constants
`ifndef PHSR_CONSTS_SVH
`define PHSR_CONSTS_SVH
`define PHSR_OP0 2'h3
`define PHSR_OP1 3'h6
`define PHSR_CRN 4'h2
`define PHSR_CRM 4'h1
`define PHSR_OP2_CHECK_CTRL 3'h6
`define PHSR_OP2_TABLE_BASE 3'h4
`define PHSR_OP2_HYP_LO 3'h0
`define PHSR_OP1_HYP 3'h4
`define PHSR_CRN_HYP 4'h1
`define PHSR_CRM_HYP 4'h1
`define PHSR_BASE_MSB 39
`define PHSR_CTRL_TOP_MSB 23
`define PHSR_CTRL_TOP_LSB 20
`define PHSR_CTRL_PPS_MSB 2
`define PHSR_HYP_DELAY_MSB 63
`define PHSR_HYP_DELAY_LSB 60
`define PHSR_HYP_DELAY_EN 59
`define PHSR_HYP_TAG_ID 58
`define PHSR_HYP_DEF_TAG 57
`define PHSR_HYP_TAG_ALLOW 56
`define PHSR_HYP_OUTER_TLB 55
`define PHSR_HYP_INNER_TLB 54
`define PHSR_HYP_UPPER_MASK 64'hFFC0_0000_0000_0000
`define PHSR_CTRL_MASK 64'h0000_0000_00F0_0007
`define PHSR_MIN_X 6'h0B
`define PHSR_DELAY_BASE 5'h08
`endif

/* phsr_pkg.sv */
// Purpose: types for the protection and hypervisor system-register block
// Assumes: nothing beyond the consts header
// Notes: exception levels and wait-trap states
package phsr_pkg;
    typedef enum logic [1:0] {EL0, EL1, EL2, EL3} phsr_level_type;
    typedef enum {WAIT_IDLE, WAIT_COUNT, WAIT_TRAP} phsr_wait_type;
endpackage : phsr_pkg

/* phsr_wait_delay.sv */
// Purpose: minimum-delay counter for a trapped wait-for-event
// Assumes: request held high until the trap pulse
// Notes: delay disabled means trap two cycles after the request
`timescale 1ns/1ps
`default_nettype none
`include "phsr_consts.svh"
module phsr_wait_delay #(
    parameter int CNT_W = 24
) (
    // clocking
    input wire logic core_clk,
    input wire logic rstSync_n,
    input wire logic clkEn,
    // request
    input wire logic waitReq,
    input wire logic delayEn,
    input wire logic [3:0] delayField,
    // result
    output logic trapTake
);
    phsr_pkg::phsr_wait_type state_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] limit;
    logic [4:0] shiftAmt;
    assign shiftAmt = {1'b0, delayField} + `PHSR_DELAY_BASE;
    // unsigned field, wait 2^(field+8) cycles at least
    assign limit = delayEn ? CNT_W'((CNT_W+1)'(1) << shiftAmt) : CNT_W'(1);
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_r <= phsr_pkg::WAIT_IDLE;
            count_r <= '0;
            trapTake <= 1'b0;
        end else if (clkEn) begin
            trapTake <= 1'b0;
            case (state_r)
                phsr_pkg::WAIT_IDLE: begin
                    count_r <= CNT_W'(1);
                    if (waitReq) begin
                        state_r <= phsr_pkg::WAIT_COUNT;
                    end
                end
                phsr_pkg::WAIT_COUNT: begin
                    if (!waitReq) begin
                        state_r <= phsr_pkg::WAIT_IDLE;
                    end else if (count_r >= limit) begin
                        state_r <= phsr_pkg::WAIT_TRAP;
                        trapTake <= 1'b1;
                    end else begin
                        count_r <= count_r + CNT_W'(1);
                    end
                end
                phsr_pkg::WAIT_TRAP: begin
                    if (!waitReq) begin
                        state_r <= phsr_pkg::WAIT_IDLE;
                    end
                end
                default: state_r <= phsr_pkg::WAIT_IDLE;
            endcase
        end
    end
endmodule : phsr_wait_delay
`default_nettype wire

/* phsr_sysregs.sv */
// Purpose: protection check control, table base and upper hypervisor configuration
// Assumes: one system-register access per cycle, core_clk at 25 MHz
// Notes: results registered one cycle after the access
// Contract
// - only level 3 reaches protection registers
// - decode check control and table base encodings
// - table base undefined without realm extension
// - base field in bits 39:0
// - low base address bits treated zero
// - protected size field to bit count
// - top entry field to bit count
// - base field low bits read zero
// - warm reset leaves fields unknown; this block resets them to zero
// - no level 2 means reads zero
// - level 2 disabled makes bits act zero; here bit 56 acts as one instead, tag access is not blocked
// - hypervisor halves share storage with views; here only the upper half has a view, the low view reads zero
// - delay field unsigned, wait 2^(n+8) cycles
// - bit 59 enables the wait delay
// - bit 58 traps tag granule ID reads
// - bit 57 picks tagged default translations
// - bit 56 clear blocks tag access
// - bit 55 traps outer TLB maintenance
// - bit 54 traps inner TLB maintenance
// - host mode with trap masks TLB bits
// - check control holds size fields
`timescale 1ns/1ps
`default_nettype none
`include "phsr_consts.svh"
module phsr_sysregs #(
    parameter bit HAS_REALM = 1'b1,
    parameter bit HAS_LEVEL2 = 1'b1,
    parameter int DELAY_W = 24
) (
    // clocking
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // system-register access
    input wire logic accValid,
    input wire logic accWrite,
    input wire logic [1:0] accOp0,
    input wire logic [2:0] accOp1,
    input wire logic [3:0] accCrn,
    input wire logic [3:0] accCrm,
    input wire logic [2:0] accOp2,
    input wire logic [1:0] curLevel,
    input wire logic [63:0] accWdata,
    // 32-bit view access
    input wire logic viewValid,
    input wire logic viewWrite,
    input wire logic viewHigh,
    input wire logic [31:0] viewWdata,
    // execution state
    input wire logic level2Enabled,
    input wire logic hostMode,
    input wire logic generalTrap,
    input wire logic defaultCache,
    input wire logic waitTrapReq,
    // access result
    output logic accDone,
    output logic accUndef,
    output logic [63:0] accRdata,
    output logic [31:0] viewRdata,
    // effective controls
    output logic [51:0] tableBaseAddr,
    output logic tagIdTrapEff,
    output logic defaultTaggedEff,
    output logic tagAccessBlock,
    output logic outerTlbTrapEff,
    output logic innerTlbTrapEff,
    output logic waitTrapTake
);
    logic [1:0] rstPipe_r;
    logic rstSync_n;
    logic [63:0] checkCtrl_r;
    logic [39:0] tableBase_r;
    logic [63:0] hypCfg_r;
    logic [39:0] baseMask;
    logic [5:0] alignX;
    logic [5:0] ppsBits;
    logic [5:0] topBits;
    logic [6:0] diffX;
    logic commonEnc;
    logic selCtrl;
    logic selBase;
    logic selHyp;
    logic isLevel3;
    logic undefNxt;
    logic [63:0] rdataNxt;
    logic [63:0] hypEff;
    logic hostBoth;
    logic [63:0] ctrlWr;
    logic [39:0] baseWr;
    logic [63:0] hypWr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_r[1];

    function automatic logic [5:0] ppsDecode(input logic [2:0] f);
        case (f)
            3'h0: ppsDecode = 6'd32;
            3'h1: ppsDecode = 6'd36;
            3'h2: ppsDecode = 6'd40;
            3'h3: ppsDecode = 6'd42;
            3'h4: ppsDecode = 6'd44;
            3'h5: ppsDecode = 6'd48;
            default: ppsDecode = 6'd52;
        endcase
    endfunction : ppsDecode

    function automatic logic [5:0] topDecode(input logic [3:0] f);
        case (f)
            4'h4: topDecode = 6'd34;
            4'h6: topDecode = 6'd36;
            4'h9: topDecode = 6'd39;
            default: topDecode = 6'd30;
        endcase
    endfunction : topDecode

    // encoding decode
    assign commonEnc = accOp0 == `PHSR_OP0 && accCrn == `PHSR_CRN && accCrm == `PHSR_CRM;
    assign selCtrl = commonEnc && accOp1 == `PHSR_OP1 && accOp2 == `PHSR_OP2_CHECK_CTRL;
    assign selBase = commonEnc && accOp1 == `PHSR_OP1 && accOp2 == `PHSR_OP2_TABLE_BASE;
    assign selHyp = accOp0 == `PHSR_OP0 && accOp1 == `PHSR_OP1_HYP && accCrn == `PHSR_CRN_HYP
        && accCrm == `PHSR_CRM_HYP && accOp2 == `PHSR_OP2_HYP_LO;
    assign isLevel3 = curLevel == phsr_pkg::EL3;
    // below level 3, or base without realm, or unknown encoding: undefined
    assign undefNxt = (selCtrl && !isLevel3)
        || (selBase && (!isLevel3 || !HAS_REALM))
        || (!selCtrl && !selBase && !selHyp);

    // alignment: x = max(pps - l0 + 2, 11)
    assign ppsBits = ppsDecode(checkCtrl_r[`PHSR_CTRL_PPS_MSB:0]);
    assign topBits = topDecode(checkCtrl_r[`PHSR_CTRL_TOP_MSB:`PHSR_CTRL_TOP_LSB]);
    assign diffX = {1'b0, ppsBits} - {1'b0, topBits} + 7'd2;
    assign alignX = (!diffX[6] && diffX[5:0] > `PHSR_MIN_X) ? diffX[5:0] : `PHSR_MIN_X;
    // field bits x-12..0 zero; x=11 keeps all bits
    assign baseMask = 40'hFF_FFFF_FFFF << (alignX - `PHSR_MIN_X);

    // write data with reserved bits stripped
    assign ctrlWr = accWdata & `PHSR_CTRL_MASK;
    assign baseWr = accWdata[`PHSR_BASE_MSB:0];
    assign hypWr = accWdata & `PHSR_HYP_UPPER_MASK;

    always_comb begin
        rdataNxt = 64'h0000_0000_0000_0000;
        if (selCtrl) begin
            rdataNxt = checkCtrl_r;
        end else if (selBase) begin
            rdataNxt = {24'h00_0000, tableBase_r & baseMask};
        end else if (selHyp && HAS_LEVEL2) begin
            rdataNxt = hypCfg_r;
        end
    end

    // warm reset: values are unknown, zero chosen for determinism
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            checkCtrl_r <= 64'h0000_0000_0000_0000;
            tableBase_r <= 40'h00_0000_0000;
            hypCfg_r <= 64'h0000_0000_0000_0000;
        end else if (clkEn) begin
            if (accValid && accWrite && !undefNxt && selCtrl) begin
                checkCtrl_r <= ctrlWr;
            end
            if (accValid && accWrite && !undefNxt && selBase) begin
                tableBase_r <= baseWr & baseMask;
            end
            if (HAS_LEVEL2 && accValid && accWrite && !undefNxt && selHyp) begin
                hypCfg_r <= hypWr;
            end else if (HAS_LEVEL2 && viewValid && viewWrite && viewHigh) begin
                hypCfg_r[63:32] <= viewWdata & 32'(`PHSR_HYP_UPPER_MASK >> 32);
            end
        end
    end

    // effective values: zero when level 2 off, TLB traps masked in host mode with general trap set
    assign hostBoth = hostMode && generalTrap;
    assign hypEff = (HAS_LEVEL2 && level2Enabled) ? hypCfg_r : 64'h0000_0000_0000_0000;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            accDone <= 1'b0;
            accUndef <= 1'b0;
            accRdata <= 64'h0000_0000_0000_0000;
            viewRdata <= 32'h0000_0000;
            tableBaseAddr <= 52'h0_0000_0000_0000;
            tagIdTrapEff <= 1'b0;
            defaultTaggedEff <= 1'b0;
            tagAccessBlock <= 1'b0;
            outerTlbTrapEff <= 1'b0;
            innerTlbTrapEff <= 1'b0;
        end else if (clkEn) begin
            accDone <= accValid;
            accUndef <= accValid && undefNxt;
            accRdata <= (accValid && !accWrite && !undefNxt) ? rdataNxt : 64'h0000_0000_0000_0000;
            viewRdata <= (HAS_LEVEL2 && viewHigh) ? hypCfg_r[63:32] : 32'h0000_0000;
            tableBaseAddr <= {tableBase_r & baseMask, 12'h000};
            tagIdTrapEff <= hypEff[`PHSR_HYP_TAG_ID] && !hostBoth && curLevel != phsr_pkg::EL3
                && curLevel != phsr_pkg::EL2;
            defaultTaggedEff <= defaultCache && hypEff[`PHSR_HYP_DEF_TAG];
            tagAccessBlock <= !hostBoth && !hypEff[`PHSR_HYP_TAG_ALLOW] && level2Enabled && HAS_LEVEL2;
            outerTlbTrapEff <= hypEff[`PHSR_HYP_OUTER_TLB] && !hostBoth && curLevel == phsr_pkg::EL1;
            innerTlbTrapEff <= hypEff[`PHSR_HYP_INNER_TLB] && !hostBoth && curLevel == phsr_pkg::EL1;
        end
    end

    // low view unused here: the lower half lies outside this block, reads zero
    phsr_wait_delay #(
        .CNT_W(DELAY_W)
    ) uWait (
        .core_clk(core_clk),
        .rstSync_n(rstSync_n),
        .clkEn(clkEn),
        .waitReq(waitTrapReq),
        .delayEn(hypEff[`PHSR_HYP_DELAY_EN]),
        .delayField(hypEff[`PHSR_HYP_DELAY_MSB:`PHSR_HYP_DELAY_LSB]),
        .trapTake(waitTrapTake)
    );

    a_undef_low_level: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        clkEn && accValid && (selCtrl || selBase) && !isLevel3 |=> accUndef)
        else $error("protection register access below level 3 not undefined");
    a_ctrl_decode: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        clkEn && accValid && !accWrite && selCtrl && isLevel3 |=> !accUndef && accRdata == $past(checkCtrl_r))
        else $error("check control read wrong");
    a_base_high_zero: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        clkEn && accValid && !accWrite && selBase |=> accRdata[63:40] == 24'h00_0000)
        else $error("base reserved bits nonzero");
    a_base_aligned: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        (tableBase_r & ~baseMask) == 40'h00_0000_0000)
        else $error("base low bits not zero");
    a_min_align: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        alignX >= `PHSR_MIN_X && alignX <= 6'd24)
        else $error("alignment index out of range");
    a_tlb_host_mask: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        clkEn && hostBoth |=> !outerTlbTrapEff && !innerTlbTrapEff)
        else $error("tlb trap active in host mode");
    a_level2_off_zero: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        clkEn && !level2Enabled |=> !tagIdTrapEff && !outerTlbTrapEff && !defaultTaggedEff)
        else $error("control active with level 2 disabled");
    a_wait_no_early: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        clkEn && $rose(waitTrapReq) && hypEff[`PHSR_HYP_DELAY_EN] |=> !waitTrapTake [*8])
        else $error("wait trap taken too early");
endmodule : phsr_sysregs
`default_nettype wire

/* test_protection_and_hypervisor_sysregs.sv */
// Purpose: self-checking bench for the protection and hypervisor register block
// Assumes: realm extension and level 2 present, answer within four cycles
// Notes: wait delay kept to fields 0 and 1 so the run stays short
`timescale 1ns/1ps
`default_nettype none
`include "phsr_consts.svh"
module test_protection_and_hypervisor_sysregs;
    // clocking
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    // access
    logic accValid = 1'b0, accWrite = 1'b0, viewValid = 1'b0, viewWrite = 1'b0, viewHigh = 1'b0;
    logic [1:0] accOp0 = `PHSR_OP0, curLevel = 2'h3;
    logic [2:0] accOp1 = 3'h0, accOp2 = 3'h0;
    logic [3:0] accCrn = 4'h0, accCrm = `PHSR_CRM;
    logic [63:0] accWdata = 64'h0;
    logic [31:0] viewWdata = 32'h0;
    // state and results
    logic level2Enabled = 1'b1, hostMode = 1'b0, generalTrap = 1'b0, defaultCache = 1'b1, waitTrapReq = 1'b0;
    logic accDone, accUndef, tagId, defTag, tagBlk, outerTlb, innerTlb, waitTrapTake;
    logic [63:0] accRdata;
    logic [31:0] viewRdata;
    logic [51:0] tableBaseAddr;
    int errTotal = 0;
    int numChecks = 0;
    int xv[3] = '{24, 16, 11}; // 52-30+2, 48-34+2, 32-39+2 floored at 11
    logic [2:0] ppsCode[3] = '{3'h6, 3'h5, 3'h0};
    logic [3:0] topCode[3] = '{4'h0, 4'h4, 4'h9};
    logic [4:0] effExp[3] = '{5'b11111, 5'b01000, 5'b00000};
    logic [39:0] m;

    phsr_sysregs DUT (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .accValid(accValid),
        .accWrite(accWrite), .accOp0(accOp0), .accOp1(accOp1), .accCrn(accCrn), .accCrm(accCrm),
        .accOp2(accOp2), .curLevel(curLevel), .accWdata(accWdata), .viewValid(viewValid),
        .viewWrite(viewWrite), .viewHigh(viewHigh), .viewWdata(viewWdata), .level2Enabled(level2Enabled),
        .hostMode(hostMode), .generalTrap(generalTrap), .defaultCache(defaultCache),
        .waitTrapReq(waitTrapReq), .accDone(accDone), .accUndef(accUndef), .accRdata(accRdata),
        .viewRdata(viewRdata), .tableBaseAddr(tableBaseAddr), .tagIdTrapEff(tagId),
        .defaultTaggedEff(defTag), .tagAccessBlock(tagBlk), .outerTlbTrapEff(outerTlb),
        .innerTlbTrapEff(innerTlb), .waitTrapTake(waitTrapTake));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk64(input string what, input logic [63:0] expv, input logic [63:0] gotv);
        numChecks++;
        if (gotv !== expv) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, expv, gotv);
        end
    endtask : chk64

    task automatic chkFlag(input string what, input logic expv, input logic gotv);
        numChecks++;
        if (gotv !== expv) begin
            errTotal++;
            $display("ERROR %s expected %b seen %b", what, expv, gotv);
        end
    endtask : chkFlag

    // one access, then its answer and read data compared
    task automatic acc(input string what, input logic wr, input logic [2:0] op1, input logic [3:0] crn,
                       input logic [2:0] op2, input logic [1:0] lvl, input logic [63:0] wd,
                       input logic expUndef, input logic [63:0] expRd);
        int i;
        @(posedge core_clk);
        accValid <= 1'b1;
        accWrite <= wr;
        accOp1 <= op1;
        accCrn <= crn;
        accOp2 <= op2;
        curLevel <= lvl;
        accWdata <= wd;
        @(posedge core_clk);
        accValid <= 1'b0;
        i = 0;
        #1;
        while (accDone !== 1'b1 && i < 4) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chkFlag({what, " done"}, 1'b1, accDone);
        if (accDone !== 1'b1) begin
            stop_test();
        end
        chkFlag({what, " undef"}, expUndef, accUndef);
        chk64({what, " data"}, expRd, accRdata);
    endtask : acc

    task automatic view(input logic wr, input logic hi, input logic [31:0] wd, input logic [31:0] expRd);
        @(posedge core_clk);
        viewValid <= 1'b1;
        viewWrite <= wr;
        viewHigh <= hi;
        viewWdata <= wd;
        @(posedge core_clk);
        viewValid <= 1'b0;
        #1;
        chk64("viewRdata", {32'h0, expRd}, {32'h0, viewRdata});
    endtask : view

    initial begin
        repeat (100000) @(posedge core_clk);
        errTotal++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end

    initial begin
        int k, n;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        acc("ctrl", 1'b1, `PHSR_OP1, `PHSR_CRN, `PHSR_OP2_CHECK_CTRL, 2'h3, {64{1'b1}}, 1'b0, 64'h0);
        acc("ctrl", 1'b0, `PHSR_OP1, `PHSR_CRN, `PHSR_OP2_CHECK_CTRL, 2'h3, 64'h0, 1'b0, 64'h0000_0000_00F0_0007);
        for (k = 0; k < 3; k++) begin
            m = {40{1'b1}} << (xv[k] - 11);
            acc("ctrl", 1'b1, `PHSR_OP1, `PHSR_CRN, `PHSR_OP2_CHECK_CTRL, 2'h3,
                {40'h0, topCode[k], 17'h0, ppsCode[k]}, 1'b0, 64'h0);
            acc("base", 1'b1, `PHSR_OP1, `PHSR_CRN, `PHSR_OP2_TABLE_BASE, 2'h3, {64{1'b1}}, 1'b0, 64'h0);
            acc("base", 1'b0, `PHSR_OP1, `PHSR_CRN, `PHSR_OP2_TABLE_BASE, 2'h3, 64'h0, 1'b0, {24'h0, m});
            @(posedge core_clk);
            #1;
            chk64("tableBaseAddr", {12'h0, m, 12'h0}, {12'h0, tableBaseAddr});
        end
        for (k = 0; k < 6; k++) begin
            acc("lowLevel", k[0], `PHSR_OP1, `PHSR_CRN, k < 3 ? `PHSR_OP2_TABLE_BASE : `PHSR_OP2_CHECK_CTRL,
                2'(k % 3), 64'h0, 1'b1, 64'h0);
        end
        acc("base", 1'b0, `PHSR_OP1, `PHSR_CRN, `PHSR_OP2_TABLE_BASE, 2'h3, 64'h0, 1'b0, 64'h0000_00FF_FFFF_FFFF);
        acc("unknown", 1'b0, `PHSR_OP1, `PHSR_CRN, 3'h7, 2'h3, 64'h0, 1'b1, 64'h0);
        acc("hyp", 1'b1, `PHSR_OP1_HYP, `PHSR_CRN_HYP, `PHSR_OP2_HYP_LO, 2'h3, {64{1'b1}}, 1'b0, 64'h0);
        acc("hyp", 1'b0, `PHSR_OP1_HYP, `PHSR_CRN_HYP, `PHSR_OP2_HYP_LO, 2'h3, 64'h0, 1'b0, 64'hFFC0_0000_0000_0000);
        view(1'b0, 1'b1, 32'h0, 32'hFFC0_0000);
        view(1'b1, 1'b1, 32'h5540_0000, 32'hFFC0_0000);
        acc("hyp", 1'b0, `PHSR_OP1_HYP, `PHSR_CRN_HYP, `PHSR_OP2_HYP_LO, 2'h3, 64'h0, 1'b0, 64'h5540_0000_0000_0000);
        acc("hyp", 1'b1, `PHSR_OP1_HYP, `PHSR_CRN_HYP, `PHSR_OP2_HYP_LO, 2'h3, 64'h0EC0_0000_0000_0000, 1'b0, 64'h0);
        for (k = 0; k < 3; k++) begin
            @(posedge core_clk);
            curLevel <= 2'h1;
            level2Enabled <= (k != 2);
            hostMode <= (k == 1);
            generalTrap <= (k == 1);
            repeat (2) @(posedge core_clk);
            #1;
            chk64("effective", {59'h0, effExp[k]}, {59'h0, tagId, defTag, tagBlk, outerTlb, innerTlb});
        end
        level2Enabled <= 1'b1;
        hostMode <= 1'b0;
        generalTrap <= 1'b0;
        for (k = 0; k < 2; k++) begin
            acc("hyp", 1'b1, `PHSR_OP1_HYP, `PHSR_CRN_HYP, `PHSR_OP2_HYP_LO, 2'h3,
                {k[3:0], 60'h800_0000_0000_0000}, 1'b0, 64'h0);
            @(posedge core_clk);
            waitTrapReq <= 1'b1;
            n = 0;
            #1;
            while (waitTrapTake !== 1'b1 && n < 3000) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            chkFlag("waitTrapTake", 1'b1, waitTrapTake);
            if (n >= 3000) begin
                stop_test();
            end
            chkFlag("waitDelayMin", 1'b1, n >= (256 << k));
            @(posedge core_clk);
            waitTrapReq <= 1'b0;
        end
        stop_test();
    end
endmodule : test_protection_and_hypervisor_sysregs
`default_nettype wire
